/* File: hw/sdf_pkg.sv */
// Constants of the stream host: its own register map and the card controller's map.
// Assumes the card controller decodes the offsets below on its register port.
package sdf_pkg;
	// Own register port offsets
	localparam logic [7:0] SDF_CTRL = 8'h00;
	localparam logic [7:0] SDF_LEN = 8'h04;
	localparam logic [7:0] SDF_TOUT = 8'h08;
	localparam logic [7:0] SDF_CIDX = 8'h0c;
	localparam logic [7:0] SDF_STAT = 8'h10;
	// Control register bits
	localparam int SDF_GO_BIT = 0;
	localparam int SDF_DIR_BIT = 1;
	localparam int SDF_DMA_BIT = 2;
	localparam int SDF_STOPC_BIT = 3;
	localparam int SDF_STARTC_BIT = 4;
	localparam int SDF_LANE_BIT = 5;
	// Card controller register offsets
	localparam logic [7:0] SDF_D_CLKSS = 8'h00;
	localparam logic [7:0] SDF_D_CMDCTL = 8'h04;
	localparam logic [7:0] SDF_D_BLKLEN = 8'h08;
	localparam logic [7:0] SDF_D_BLKCNT = 8'h0c;
	localparam logic [7:0] SDF_D_RDTO = 8'h10;
	localparam logic [7:0] SDF_D_MASK = 8'h14;
	localparam logic [7:0] SDF_D_CMDIDX = 8'h18;
	localparam logic [7:0] SDF_D_PART = 8'h1c;
	localparam logic [7:0] SDF_D_RXBUF = 8'h20;
	localparam logic [7:0] SDF_D_TXBUF = 8'h24;
	// Card controller field values
	localparam logic [31:0] SDF_CLK_STOP = 32'h0000_0001;
	localparam logic [31:0] SDF_CLK_START = 32'h0000_0002;
	localparam logic [31:0] SDF_MASK_CLKOFF = 32'hffff_ffef;
	localparam logic [31:0] SDF_PART_SET = 32'h0000_0001;
	localparam logic [31:0] SDF_ONE_BLOCK = 32'h0000_0001;
	localparam logic [31:0] SDF_STOP_INDEX = 32'h0000_000c;
	localparam logic [31:0] SDF_CC_DATA = 32'h0000_0004;
	localparam logic [31:0] SDF_CC_WRITE = 32'h0000_0008;
	localparam logic [31:0] SDF_CC_STREAM = 32'h0000_0010;
	localparam logic [31:0] SDF_CC_DMA = 32'h0000_0080;
	localparam logic [31:0] SDF_CC_LANE = 32'h0000_0100;
	localparam logic [3:0] SDF_BE_BYTE = 4'h1;
	localparam logic [3:0] SDF_BE_WORD = 4'hf;
	// Cycles to ignore request lines after a burst, covering the synchroniser lag
	localparam logic [2:0] SDF_GUARD = 3'h5;
	typedef enum logic [4:0] {
		SDF_IDLE, SDF_LEN_W, SDF_CNT_W, SDF_TO_W, SDF_IDX_W, SDF_CC_W,
		SDF_WREQ, SDF_BURST, SDF_TAIL, SDF_PART_W, SDF_GUARD_S, SDF_WSTOP,
		SDF_SIDX_W, SDF_SCC_W, SDF_WDONE, SDF_MASK_W, SDF_STOP_W,
		SDF_COFF, SDF_START_W
	} sdf_state_t;
endpackage

/* File: hw/sdf_host.sv */
// Stream transfer host that drives a card controller through its register port.
// Assumes device flags arrive as unsynchronised levels and device read data one cycle late.
// Summary of operation
// - Host sets partial fill bit after an unfilled transmit burst.
// - Host moves data as single-byte accesses in bursts of 32.
// - Host waits for a service request and moves at most 32 bytes each.
// - Host sets the DMA select bit for DMA, clears it for programmed I/O.
// - Host unmasks clock-off, sets stop, waits flag; start bit restarts clock.
// - Stream write sends stop command once device signals ready for stop.
// - Stream write programs total length and a block count of one.
// - Stream read programs length, count one, timeout, stream set, write clear.
// - Stream read sends stop command only after all data was read.
// - Stream write sets write, stream and data enable before the command.
`timescale 1ns/1ps
module sdf_host #(
	parameter int BURST_LEN = 32
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Own register port
	input wire logic [7:0] sw_addr_i,
	input wire logic [31:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [31:0] sw_rdata_o,
	// Byte streams
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	// Card controller register port
	output logic [7:0] dev_addr_o,
	output logic [31:0] dev_wdata_o,
	output logic [3:0] dev_be_o,
	output logic dev_wr_o,
	output logic dev_rd_o,
	input wire logic [31:0] dev_rdata_i,
	// Card controller flags
	input wire logic dev_rx_req_i,
	input wire logic dev_tx_req_i,
	input wire logic dev_stop_ready_i,
	input wire logic dev_clk_off_i,
	input wire logic dev_done_i
);
	import sdf_pkg::*;

	sdf_state_t state;
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic rx_req, tx_req, stop_rdy, clk_off, xfer_done;
	logic go, dir_wr, dma_en, lane4, busy, done;
	logic [15:0] len;
	logic [31:0] tout;
	logic [5:0] cidx;
	logic [15:0] remain;
	logic [6:0] burst_cnt;
	logic [6:0] burst_max;
	logic partial;
	logic rd_pend;
	logic [2:0] guard;
	logic clk_stop_req, clk_start_req;

	assign go = sw_wr_i && sw_addr_i == SDF_CTRL && sw_wdata_i[SDF_GO_BIT] && !busy;
	assign rx_req = sync_b[0];
	assign tx_req = sync_b[1];
	assign stop_rdy = sync_b[2];
	assign clk_off = sync_b[3];
	assign xfer_done = sync_b[4];
	assign tx_ready_o = state == SDF_BURST && dir_wr && burst_cnt < burst_max;

	// Flags come from the card controller's own timing, so each passes two flip-flops
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {dev_done_i, dev_clk_off_i, dev_stop_ready_i, dev_tx_req_i, dev_rx_req_i};
			sync_b <= sync_a;
		end
	end

	// Own configuration registers
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			dir_wr <= 1'b0;
			dma_en <= 1'b0;
			lane4 <= 1'b0;
			len <= '0;
			tout <= '0;
			cidx <= '0;
		end else if (sw_wr_i && !busy) begin
			if (sw_addr_i == SDF_CTRL) begin
				dir_wr <= sw_wdata_i[SDF_DIR_BIT];
				dma_en <= sw_wdata_i[SDF_DMA_BIT];
				lane4 <= sw_wdata_i[SDF_LANE_BIT];
			end else if (sw_addr_i == SDF_LEN) begin
				len <= sw_wdata_i[15:0];
			end else if (sw_addr_i == SDF_TOUT) begin
				tout <= sw_wdata_i;
			end else if (sw_addr_i == SDF_CIDX) begin
				cidx <= sw_wdata_i[5:0];
			end
		end
	end

	// Clock orders are held until the engine is idle to take them
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			clk_stop_req <= 1'b0;
			clk_start_req <= 1'b0;
		end else begin
			if (sw_wr_i && sw_addr_i == SDF_CTRL && sw_wdata_i[SDF_STOPC_BIT]) begin
				clk_stop_req <= 1'b1;
			end else if (state == SDF_MASK_W) begin
				clk_stop_req <= 1'b0;
			end
			if (sw_wr_i && sw_addr_i == SDF_CTRL && sw_wdata_i[SDF_STARTC_BIT]) begin
				clk_start_req <= 1'b1;
			end else if (state == SDF_START_W) begin
				clk_start_req <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			sw_rdata_o <= '0;
		end else if (sw_rd_i) begin
			if (sw_addr_i == SDF_CTRL) begin
				sw_rdata_o <= {26'h000_0000, lane4, 2'b00, dma_en, dir_wr, 1'b0};
			end else if (sw_addr_i == SDF_LEN) begin
				sw_rdata_o <= {16'h0000, len};
			end else if (sw_addr_i == SDF_TOUT) begin
				sw_rdata_o <= tout;
			end else if (sw_addr_i == SDF_CIDX) begin
				sw_rdata_o <= {26'h000_0000, cidx};
			end else if (sw_addr_i == SDF_STAT) begin
				sw_rdata_o <= {13'h0000, remain, clk_off, done, busy};
			end else begin
				sw_rdata_o <= '0;
			end
		end else begin
			sw_rdata_o <= '0;
		end
	end

	// Main sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state <= SDF_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			remain <= '0;
			burst_cnt <= '0;
			burst_max <= '0;
			partial <= 1'b0;
			guard <= '0;
		end else begin
			case (state)
				SDF_IDLE: begin
					if (go) begin
						busy <= 1'b1;
						done <= 1'b0;
						remain <= len;
						state <= SDF_LEN_W;
					end else if (clk_stop_req) begin
						busy <= 1'b1;
						state <= SDF_MASK_W;
					end else if (clk_start_req) begin
						state <= SDF_START_W;
					end
				end
				SDF_LEN_W: state <= SDF_CNT_W;
				SDF_CNT_W: state <= SDF_TO_W;
				SDF_TO_W: state <= SDF_IDX_W;
				SDF_IDX_W: state <= SDF_CC_W;
				SDF_CC_W: state <= SDF_WREQ;
				SDF_WREQ: begin
					if (remain == 16'h0000) begin
						state <= dir_wr ? SDF_WSTOP : SDF_SIDX_W;
					end else if (dir_wr ? tx_req : rx_req) begin
						burst_cnt <= '0;
						if (remain < 16'(BURST_LEN)) begin
							burst_max <= remain[6:0];
							partial <= 1'b1;
						end else begin
							burst_max <= 7'(BURST_LEN);
							partial <= 1'b0;
						end
						state <= SDF_BURST;
					end
				end
				SDF_BURST: begin
					if (dev_wr_o || dev_rd_o) begin
						burst_cnt <= burst_cnt + 7'h01;
						remain <= remain - 16'h0001;
					end
					if (burst_cnt == burst_max) begin
						state <= dir_wr ? (partial ? SDF_PART_W : SDF_GUARD_S) : SDF_TAIL;
					end
					guard <= SDF_GUARD;
				end
				SDF_TAIL: state <= SDF_GUARD_S;
				SDF_PART_W: state <= SDF_GUARD_S;
				SDF_GUARD_S: begin
					guard <= guard - 3'h1;
					if (guard == 3'h0) begin
						state <= SDF_WREQ;
					end
				end
				SDF_WSTOP: begin
					if (stop_rdy) begin
						state <= SDF_SIDX_W;
					end
				end
				SDF_SIDX_W: state <= SDF_SCC_W;
				SDF_SCC_W: state <= SDF_WDONE;
				SDF_WDONE: begin
					if (xfer_done) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= SDF_IDLE;
					end
				end
				SDF_MASK_W: state <= SDF_STOP_W;
				SDF_STOP_W: state <= SDF_COFF;
				SDF_COFF: begin
					if (clk_off) begin
						busy <= 1'b0;
						state <= SDF_IDLE;
					end
				end
				SDF_START_W: state <= SDF_IDLE;
				default: state <= SDF_IDLE;
			endcase
		end
	end

	// Register accesses toward the card controller
	always_comb begin
		dev_addr_o = '0;
		dev_wdata_o = '0;
		dev_be_o = SDF_BE_WORD;
		dev_wr_o = 1'b0;
		dev_rd_o = 1'b0;
		case (state)
			SDF_LEN_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_BLKLEN;
				dev_wdata_o = {16'h0000, len};
			end
			SDF_CNT_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_BLKCNT;
				dev_wdata_o = SDF_ONE_BLOCK;
			end
			SDF_TO_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_RDTO;
				dev_wdata_o = tout;
			end
			SDF_IDX_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CMDIDX;
				dev_wdata_o = {26'h000_0000, cidx};
			end
			SDF_CC_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CMDCTL;
				dev_wdata_o = SDF_CC_DATA | SDF_CC_STREAM;
				if (dir_wr) begin
					dev_wdata_o = dev_wdata_o | SDF_CC_WRITE;
				end
				if (dma_en) begin
					dev_wdata_o = dev_wdata_o | SDF_CC_DMA;
				end
				if (lane4) begin
					dev_wdata_o = dev_wdata_o | SDF_CC_LANE;
				end
			end
			SDF_BURST: begin
				dev_be_o = SDF_BE_BYTE;
				if (burst_cnt < burst_max) begin
					if (dir_wr) begin
						dev_wr_o = tx_valid_i;
						dev_addr_o = SDF_D_TXBUF;
						dev_wdata_o = {24'h00_0000, tx_data_i};
					end else begin
						dev_rd_o = 1'b1;
						dev_addr_o = SDF_D_RXBUF;
					end
				end
			end
			SDF_PART_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_PART;
				dev_wdata_o = SDF_PART_SET;
			end
			SDF_SIDX_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CMDIDX;
				dev_wdata_o = SDF_STOP_INDEX;
			end
			SDF_SCC_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CMDCTL;
				dev_wdata_o = '0;
			end
			SDF_MASK_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_MASK;
				dev_wdata_o = SDF_MASK_CLKOFF;
			end
			SDF_STOP_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CLKSS;
				dev_wdata_o = SDF_CLK_STOP;
			end
			SDF_START_W: begin
				dev_wr_o = 1'b1;
				dev_addr_o = SDF_D_CLKSS;
				dev_wdata_o = SDF_CLK_START;
			end
			default: begin
				dev_wr_o = 1'b0;
			end
		endcase
	end

	// Read data stand one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rd_pend <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= '0;
		end else begin
			rd_pend <= dev_rd_o;
			rx_valid_o <= rd_pend;
			if (rd_pend) begin
				rx_data_o <= dev_rdata_i[7:0];
			end
		end
	end

	a_burst_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_BURST |-> burst_cnt <= 7'(BURST_LEN))
		else $error("burst moved more than the burst length");
	a_byte_lanes: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(dev_wr_o || dev_rd_o) && (dev_addr_o == SDF_D_TXBUF || dev_addr_o == SDF_D_RXBUF)
		|-> dev_be_o == SDF_BE_BYTE)
		else $error("data buffer access not single byte");
	a_partial_mark: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_BURST && dir_wr && partial && burst_cnt == burst_max
		|=> dev_wr_o && dev_addr_o == SDF_D_PART && dev_wdata_o == SDF_PART_SET)
		else $error("short transmit burst not marked partial");
	a_stop_ready: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		dev_wr_o && dev_addr_o == SDF_D_CMDIDX && dev_wdata_o == SDF_STOP_INDEX && dir_wr
		|-> $past(stop_rdy))
		else $error("stop command sent before ready for stop");
	a_count_one: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		dev_wr_o && dev_addr_o == SDF_D_CMDCTL && dev_wdata_o[4]
		|-> $past(dev_addr_o, 3) == SDF_D_BLKCNT && $past(dev_wdata_o, 3) == SDF_ONE_BLOCK
		&& $past(dev_addr_o, 4) == SDF_D_BLKLEN)
		else $error("block length and count not programmed first");
	a_read_dir: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		dev_wr_o && dev_addr_o == SDF_D_CMDCTL && state == SDF_CC_W && !dir_wr
		|-> !dev_wdata_o[3] && dev_wdata_o[4] && $past(dev_addr_o, 2) == SDF_D_RDTO)
		else $error("stream read command set wrongly");
	a_write_dir: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_CC_W && dir_wr |-> (dev_wdata_o & 32'h0000_001c) == 32'h0000_001c)
		else $error("stream write command set wrongly");
	a_dma_select: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_CC_W |-> dev_wdata_o[7] == dma_en)
		else $error("DMA select bit differs from order");
	a_read_all: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_SIDX_W && !dir_wr |-> remain == 16'h0000 && !rd_pend)
		else $error("stop sent before all read data");
	a_clock_stop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		dev_wr_o && dev_addr_o == SDF_D_CLKSS && dev_wdata_o == SDF_CLK_STOP
		|-> $past(dev_addr_o) == SDF_D_MASK && $past(dev_wdata_o) == SDF_MASK_CLKOFF
		##1 state == SDF_COFF)
		else $error("clock stop without unmasking clock-off");
	c_write_done: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_WDONE && dir_wr && xfer_done);
	c_read_done: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_WDONE && !dir_wr && xfer_done);
	c_clock_off: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_COFF && clk_off);
	c_partial: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state == SDF_PART_W);
endmodule

/* File: verif/sdf_card_model.sv */
// Behavioural card controller, reached only through its register port.
// Assumes one host access per cycle and that read data is wanted in the following cycle.
`timescale 1ns/1ps
module sdf_card_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] be_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Flags
	output logic rx_req_o,
	output logic tx_req_o,
	output logic stop_ready_o,
	output logic clk_off_o,
	output logic done_o
);
	import sdf_pkg::*;
	logic [31:0] blklen, blkcnt, rdto, cmdctl_start, last_idx, mask, clkss, got, part_cnt;
	logic xfer, dir, err, stop_early;
	logic [5:0] fill;
	logic [1:0] hold;
	logic [2:0] done_cnt, off_cnt;
	logic [7:0] tx_mem [0:255];

	function automatic logic [7:0] rx_byte(input logic [31:0] k);
		return 8'h5a ^ k[7:0];
	endfunction

	// Requests drop for two cycles after each swap, so an overlong burst hits a closed buffer
	// The drop also stands for the bus clock pausing while both halves are full or empty
	assign tx_req_o = xfer && dir && got < blklen && hold == 2'h0;
	assign rx_req_o = xfer && !dir && got < blklen && hold == 2'h0;

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			{blklen, blkcnt, rdto, cmdctl_start, last_idx, clkss, got, part_cnt} <= '0;
			mask <= 32'hffff_ffff;
			{xfer, dir, err, stop_early, stop_ready_o, clk_off_o, done_o} <= '0;
			{fill, hold, done_cnt, off_cnt} <= '0;
			rdata_o <= '0;
		end else begin
			if (hold != 2'h0) hold <= hold - 2'h1;
			if (wr_i) begin
				case (addr_i)
				SDF_D_BLKLEN: blklen <= wdata_i;
				SDF_D_BLKCNT: blkcnt <= wdata_i;
				SDF_D_RDTO: rdto <= wdata_i;
				SDF_D_MASK: mask <= wdata_i;
				SDF_D_CMDIDX: begin
					last_idx <= wdata_i;
					if (wdata_i == SDF_STOP_INDEX && got < blklen) stop_early <= 1'b1;
				end
				SDF_D_CMDCTL: begin
					if (wdata_i[2]) begin
						{got, fill, hold, done_o, stop_ready_o} <= '0;
						xfer <= 1'b1;
						dir <= wdata_i[3];
						cmdctl_start <= wdata_i;
					end else if (last_idx == SDF_STOP_INDEX) begin
						done_cnt <= 3'h4;
					end
				end
				SDF_D_TXBUF: begin
					if (!xfer || !dir || hold != 2'h0 || be_i != SDF_BE_BYTE) err <= 1'b1;
					tx_mem[got[7:0]] <= wdata_i[7:0];
					got <= got + 32'h0000_0001;
					fill <= (fill == 6'd31) ? 6'd0 : fill + 6'd1;
					if (fill == 6'd31) hold <= 2'h2;
				end
				SDF_D_PART: begin
					part_cnt <= part_cnt + 32'h0000_0001;
					fill <= 6'd0;
					hold <= 2'h2;
				end
				SDF_D_CLKSS: begin
					clkss <= wdata_i;
					// Stopping with the clock-off flag masked would leave software waiting forever
					if (wdata_i == SDF_CLK_STOP && mask[4]) err <= 1'b1;
					if (wdata_i == SDF_CLK_STOP) off_cnt <= 3'h3;
					if (wdata_i == SDF_CLK_START) clk_off_o <= 1'b0;
				end
				default: ;
				endcase
			end
			if (rd_i && addr_i == SDF_D_RXBUF) begin
				if (!xfer || dir || hold != 2'h0 || got >= blklen) err <= 1'b1;
				rdata_o <= {rx_byte(got + 3), rx_byte(got + 2), rx_byte(got + 1), rx_byte(got)};
				got <= got + 32'h0000_0001;
				if (got[4:0] == 5'd31) hold <= 2'h2;
			end else begin
				// Nothing valid is shown outside a read answer
				rdata_o <= ~rdata_o;
			end
			if (xfer && dir && got == blklen) stop_ready_o <= 1'b1;
			if (off_cnt != 3'h0) off_cnt <= off_cnt - 3'h1;
			if (off_cnt == 3'h1) clk_off_o <= 1'b1;
			if (done_cnt != 3'h0) done_cnt <= done_cnt - 3'h1;
			if (done_cnt == 3'h1) begin
				done_o <= 1'b1;
				xfer <= 1'b0;
				stop_ready_o <= 1'b0;
			end
		end
	end
endmodule

/* File: verif/sdf_host_tb_top.sv */
// Self-checking bench for the stream host against the behavioural card controller.
// Assumes a 125 MHz clock and the host's register map from the package.
`timescale 1ns/1ps
module sdf_host_tb_top;
	import sdf_pkg::*;
	logic ref_clk_i, resetn_i, sw_wr_i, sw_rd_i, tx_valid_i, tx_ready_o, tx_take, rx_valid_o;
	logic [7:0] sw_addr_i, tx_data_i, rx_data_o, dev_addr_o;
	logic [31:0] sw_wdata_i, sw_rdata_o, dev_wdata_o, dev_rdata_i, rd_word;
	logic [3:0] dev_be_o;
	logic dev_wr_o, dev_rd_o, dev_rx_req_i, dev_tx_req_i, dev_stop_ready_i, dev_clk_off_i;
	logic dev_done_i;
	int mismatches, check_count, tx_idx, tx_total, rx_n;
	logic [7:0] rx_q [0:255];

	always #4 ref_clk_i = ~ref_clk_i;

	sdf_host #(.BURST_LEN(32)) u_sdf_host (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
		.dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_be_o(dev_be_o),
		.dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o), .dev_rdata_i(dev_rdata_i),
		.dev_rx_req_i(dev_rx_req_i), .dev_tx_req_i(dev_tx_req_i),
		.dev_stop_ready_i(dev_stop_ready_i), .dev_clk_off_i(dev_clk_off_i), .dev_done_i(dev_done_i));

	sdf_card_model u_sdf_card_model (.clk_i(ref_clk_i), .rstn_i(resetn_i), .addr_i(dev_addr_o),
		.wdata_i(dev_wdata_o), .be_i(dev_be_o), .wr_i(dev_wr_o), .rd_i(dev_rd_o),
		.rdata_o(dev_rdata_i), .rx_req_o(dev_rx_req_i), .tx_req_o(dev_tx_req_i),
		.stop_ready_o(dev_stop_ready_i), .clk_off_o(dev_clk_off_i), .done_o(dev_done_i));

	function automatic logic [7:0] tx_pat(input int k);
		return 8'(k * 7 + 3);
	endfunction

	// Take is judged at the falling edge so the rising edge never races the ready output
	always @(negedge ref_clk_i) tx_take <= tx_valid_i && tx_ready_o;
	always @(posedge ref_clk_i) begin
		if (tx_take) begin
			tx_idx <= tx_idx + 1;
			tx_data_i <= tx_pat(tx_idx + 1);
			tx_valid_i <= (tx_idx + 1 < tx_total);
		end
	end
	always @(negedge ref_clk_i) begin
		if (rx_valid_o === 1'b1) begin
			rx_q[rx_n[7:0]] <= rx_data_o;
			rx_n <= rx_n + 1;
		end
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		sw_wr_i <= 1'b0;
	endtask

	task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		sw_rd_i <= 1'b0;
		@(negedge ref_clk_i);
		d = sw_rdata_o;
	endtask

	task automatic wait_stat(input int bitn, input logic v);
		for (int i = 0; i < 500; i++) begin
			sw_read(SDF_STAT, rd_word);
			if (rd_word[bitn] === v) return;
		end
		mismatches++;
		$display("wrong value at %0t: status bit %0d never reached", $time, bitn);
		test_done();
	endtask

	task automatic test_reset;
		sw_read(SDF_STAT, rd_word);
		check_val(rd_word, 32'h0000_0000, "status after reset");
		check_val({31'h0, tx_ready_o}, 32'h0000_0000, "ready after reset");
		sw_read(8'h40, rd_word);
		check_val(rd_word, 32'h0000_0000, "unmapped read");
		$display("test reset done");
	endtask

	task automatic test_write;
		@(posedge ref_clk_i);
		tx_idx <= 0;
		tx_total <= 40;
		tx_data_i <= tx_pat(0);
		tx_valid_i <= 1'b1;
		sw_write(SDF_LEN, 32'h0000_0028);
		sw_write(SDF_CIDX, 32'h0000_0019);
		sw_write(SDF_CTRL, 32'h0000_0007);
		wait_stat(1, 1'b1);
		check_val(u_sdf_card_model.blklen, 32'h0000_0028, "write length");
		check_val(u_sdf_card_model.blkcnt, SDF_ONE_BLOCK, "write count");
		check_val(u_sdf_card_model.cmdctl_start, 32'h0000_009c, "write control");
		check_val(u_sdf_card_model.got, 32'h0000_0028, "bytes sent");
		check_val(u_sdf_card_model.part_cnt, 32'h0000_0001, "partial marks");
		check_val(u_sdf_card_model.last_idx, SDF_STOP_INDEX, "stop index");
		check_val({31'h0, u_sdf_card_model.stop_early}, 32'h0000_0000, "early stop");
		check_val({31'h0, u_sdf_card_model.err}, 32'h0000_0000, "write protocol");
		for (int k = 0; k < 40; k++) begin
			check_val({24'h0, u_sdf_card_model.tx_mem[k]}, {24'h0, tx_pat(k)}, "sent byte");
		end
		$display("test write done");
	endtask

	task automatic test_read;
		@(posedge ref_clk_i);
		rx_n <= 0;
		sw_write(SDF_LEN, 32'h0000_0022);
		sw_write(SDF_TOUT, 32'h0000_0055);
		sw_write(SDF_CIDX, 32'h0000_0012);
		sw_write(SDF_CTRL, 32'h0000_0021);
		wait_stat(1, 1'b1);
		check_val(u_sdf_card_model.rdto, 32'h0000_0055, "read timeout");
		check_val(u_sdf_card_model.blkcnt, SDF_ONE_BLOCK, "read count");
		check_val(u_sdf_card_model.cmdctl_start, 32'h0000_0114, "read control");
		check_val({31'h0, u_sdf_card_model.stop_early}, 32'h0000_0000, "stop before data");
		check_val({31'h0, u_sdf_card_model.err}, 32'h0000_0000, "read protocol");
		check_val(32'(rx_n), 32'h0000_0022, "bytes received");
		sw_read(SDF_LEN, rd_word);
		check_val(rd_word, 32'h0000_0022, "length readback");
		sw_read(SDF_TOUT, rd_word);
		check_val(rd_word, 32'h0000_0055, "timeout readback");
		sw_read(SDF_CTRL, rd_word);
		check_val(rd_word, 32'h0000_0020, "control readback");
		for (int k = 0; k < 34; k++) begin
			check_val({24'h0, rx_q[k]}, {24'h0, 8'h5a ^ 8'(k)}, "received byte");
		end
		$display("test read done");
	endtask

	task automatic test_clock;
		sw_write(SDF_CTRL, 32'h0000_0008);
		wait_stat(2, 1'b1);
		check_val(u_sdf_card_model.mask, SDF_MASK_CLKOFF, "clock-off unmasked");
		check_val({31'h0, u_sdf_card_model.err}, 32'h0000_0000, "stop order");
		sw_write(SDF_CTRL, 32'h0000_0010);
		wait_stat(2, 1'b0);
		check_val(u_sdf_card_model.clkss, SDF_CLK_START, "clock restart");
		$display("test clock done");
	endtask

	initial begin
		ref_clk_i = 1'b0;
		resetn_i = 1'b0;
		{sw_wr_i, sw_rd_i, tx_valid_i, tx_take} = '0;
		{sw_addr_i, tx_data_i, sw_wdata_i} = '0;
		{mismatches, check_count, tx_idx, tx_total, rx_n} = '0;
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		test_reset();
		test_write();
		test_read();
		test_clock();
		test_done();
	end

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		mismatches++;
		$display("wrong value at %0t: run limit reached", $time);
		test_done();
	end
endmodule
